// *** core/ssnu_pkg.sv ***
// Constants shared by the serial add, shift and normalize unit
`default_nettype none
package ssnu_pkg;
  localparam int WORD_BITS = 24;
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int OPC_W     = 6;
  localparam int BIT_IDX_W = 5;

  // Bit-time indices, P1 is index zero and the least significant bit
  localparam logic [BIT_IDX_W-1:0] IDX_P1  = 5'h00;
  localparam logic [BIT_IDX_W-1:0] IDX_P2  = 5'h01;
  localparam logic [BIT_IDX_W-1:0] IDX_P23 = 5'h16;
  localparam logic [BIT_IDX_W-1:0] IDX_P24 = 5'h17;

  // Opcode bit positions (bit one of the opcode sits at position zero)
  localparam int OPC_B1 = 0;
  localparam int OPC_B2 = 1;
  localparam int OPC_B3 = 2;
  localparam int OPC_B4 = 3;
  localparam int OPC_B5 = 4;
  localparam int OPC_B6 = 5;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_REG_A  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_REG_B  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_REG_C  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_LINE   = 8'h14;

  // Field positions
  localparam int CTRL_GO_BIT  = 8;
  localparam int LINE_SEL_LSB = 8;
  localparam int STAT_TIME_LSB = 8;

  // Values after reset
  localparam logic [OPC_W-1:0]     RST_OPC  = 6'h00;
  localparam logic [WORD_BITS-1:0] RST_WORD = 24'h000000;
  localparam logic [5:0]           RST_LINE = 6'h00;
  localparam logic [2:0]           RST_SEL  = 3'h0;

  typedef enum logic [1:0] {PH_IDLE, PH_LOOKUP, PH_WAIT, PH_RUN} ssnu_phase_e;
endpackage : ssnu_pkg
`default_nettype wire

// *** core/ssnu_core.sv ***
// Bit-serial add, subtract, normalize and left-shift datapath, APB slave
//
// Overview of operation
// - P24 in lookup sets run flag; lookup clears at P24 on match.
// - Adder sum is x XOR y XOR carry latch, every bit time.
// - In run, not P1/P24: carry sets on both ones, clears on both zeros.
// - Subtract feeds the inverted memory fetch bit to adder x.
// - Subtract presets carry at lookup P24 on address match.
// - Overflow sets at run P23 on sign-carry mismatch of add/subtract.
// - Arithmetic sum goes to A when opcode bit 2 clear, else B.
// - Double-length clears opcode bit 2 at first-word P24, keeps carry.
// - Single-word add/subtract leaves run at P24 after one word.
// - Normalize and shift go straight from lookup to run.
// - B delay bit follows B; B rewritten from it except at P2.
// - A delay bit follows A; A rewritten from it except P2, P23.
// - Link bit takes B written at P24, inserted into A at P2.
// - Normalize recirculates the A sign position at P23.
// - Normalize sets opcode bit 3 when A sign would change.
// - After termination A, B recirculate, C via adder until match.
// - C decrements only when selected line bit is zero.
// - Shifts feed C to adder y and rewrite C from the sum.
// - Plain and decrementing left shift share one logic path.
// - Shift and normalize end run at P24 once match flag set.
`default_nettype none
module ssnu_core (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        ce,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [ssnu_pkg::ADDR_W-1:0] paddr,
  input  wire logic [ssnu_pkg::DATA_W-1:0] pwdata,
  output var  logic [ssnu_pkg::DATA_W-1:0] prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        memoryFetchBit,
  input  wire logic                        addressMatchFlag,
  output logic                             runPhaseFlag,
  output logic                             lookupPhaseFlag,
  output logic                             overflowFlag,
  output logic                             busy
);
  localparam int W = ssnu_pkg::WORD_BITS;

  ssnu_pkg::ssnu_phase_e      phase_q;
  ssnu_pkg::ssnu_phase_e      phase_d;
  logic [ssnu_pkg::BIT_IDX_W-1:0] bitIdx_q;
  logic [ssnu_pkg::OPC_W-1:0] opc_q;
  logic [W-1:0]               regA_q;
  logic [W-1:0]               regB_q;
  logic [W-1:0]               regC_q;
  logic [5:0]                 lineNum_q;
  logic [2:0]                 lineSel_q;
  logic                       pending_q;
  logic                       serialCinLatch_q;
  logic                       overflow_q;
  logic                       aDelayBit_q;
  logic                       bDelayBit_q;
  logic                       bToALinkBit_q;
  logic [ssnu_pkg::DATA_W-1:0] rdata_q;
  // Bit-time decode
  wire p1  = (bitIdx_q == ssnu_pkg::IDX_P1);
  wire p2  = (bitIdx_q == ssnu_pkg::IDX_P2);
  wire p23 = (bitIdx_q == ssnu_pkg::IDX_P23);
  wire p24 = (bitIdx_q == ssnu_pkg::IDX_P24);

  // Opcode decode
  wire o1 = opc_q[ssnu_pkg::OPC_B1];
  wire opcodeBit2 = opc_q[ssnu_pkg::OPC_B2];
  wire opcodeBit3 = opc_q[ssnu_pkg::OPC_B3];
  wire o4 = opc_q[ssnu_pkg::OPC_B4];
  wire o5 = opc_q[ssnu_pkg::OPC_B5];
  wire o6 = opc_q[ssnu_pkg::OPC_B6];
  wire isArith  = !o6 && !o5 && o4 && opcodeBit3;
  wire isSub    = isArith && o1;
  wire isShift  = !o6 && o5 && !o4 && !opcodeBit2;
  wire isNorm   = isShift && !o1;
  wire shiftAct = isShift && !opcodeBit3;

  // Phase flags
  wire lookupPhase = (phase_q == ssnu_pkg::PH_LOOKUP) ||
                     (phase_q == ssnu_pkg::PH_WAIT);
  wire runPhase    = (phase_q == ssnu_pkg::PH_WAIT) ||
                     (phase_q == ssnu_pkg::PH_RUN);
  wire inRun       = (phase_q == ssnu_pkg::PH_RUN);
  wire active      = (phase_q != ssnu_pkg::PH_IDLE);

  // Serial read bits
  wire aReadBit = regA_q[0];
  wire bReadBit = regB_q[0];
  wire cReadBit = regC_q[0];
  wire lineSelectFour = lineNum_q[lineSel_q];

  // Adder inputs; active shifts with the selected line bit zero add all ones above P1, i.e. minus one per word
  wire arithX = isSub ? !memoryFetchBit : memoryFetchBit;
  wire decX   = shiftAct && !lineSelectFour && !p1;
  wire adderXIn = isArith ? arithX : decX;
  wire adderYIn = isArith ? (opcodeBit2 ? bReadBit : aReadBit)
                          : (isShift && cReadBit);
  wire adderSum = adderXIn ^ adderYIn ^ serialCinLatch_q;
  wire carryWin   = inRun && !p1 && !p24;
  wire carrySet   = carryWin && adderXIn && adderYIn && !serialCinLatch_q;
  wire carryClr   = carryWin && !adderXIn && !adderYIn;
  wire subPreset  = lookupPhase && p24 && addressMatchFlag && isSub;
  // The low word of a double add writes B and never flags overflow
  wire ovfEvent   = p23 && inRun && isArith && !opcodeBit2 &&
                    ((!adderXIn && !adderYIn && serialCinLatch_q) ||
                     (adderXIn && adderYIn && !serialCinLatch_q));
  wire normStop   = inRun && isNorm && !opcodeBit3 && p23 &&
                    (aDelayBit_q != aReadBit);

  // Serial write bits
  logic aWriteBit;
  logic bWriteBit;
  logic cWriteBit;

  always_comb
  begin
    aWriteBit = aReadBit;
    bWriteBit = bReadBit;
    cWriteBit = cReadBit;
    if (inRun && isArith)
    begin
      if (opcodeBit2)
        bWriteBit = adderSum;
      else
        aWriteBit = adderSum;
    end
    if (inRun && shiftAct)
    begin
      if (p2)
        aWriteBit = bToALinkBit_q;
      else if (p23)
        aWriteBit = aReadBit;
      else
        aWriteBit = aDelayBit_q;
      bWriteBit = p2 ? 1'b0 : bDelayBit_q;
    end
    // After termination only C keeps flowing through the adder
    if (inRun && isShift)
      cWriteBit = adderSum;
  end

  // Phase sequencing, evaluated at the word boundary only
  always_comb
  begin
    phase_d = phase_q;
    case (phase_q)
      ssnu_pkg::PH_IDLE:
        if (p24 && pending_q)
          phase_d = ssnu_pkg::PH_LOOKUP;
      ssnu_pkg::PH_LOOKUP:
        if (p24)
        begin
          if (isShift || addressMatchFlag)
            phase_d = ssnu_pkg::PH_RUN;
          else
            phase_d = ssnu_pkg::PH_WAIT;
        end
      ssnu_pkg::PH_WAIT:
        if (p24 && addressMatchFlag)
          phase_d = ssnu_pkg::PH_RUN;
      ssnu_pkg::PH_RUN:
        if (p24)
        begin
          if (isArith && !opcodeBit2)
            phase_d = ssnu_pkg::PH_IDLE;
          else if (isShift && addressMatchFlag)
            phase_d = ssnu_pkg::PH_IDLE;
        end
      default:
        phase_d = ssnu_pkg::PH_IDLE;
    endcase
  end

  // APB decode
  wire apbAccess = psel && penable && ce;
  wire apbSetup  = psel && !penable && ce;
  wire hitCtrl   = (paddr == ssnu_pkg::OFS_CTRL);
  wire hitStat   = (paddr == ssnu_pkg::OFS_STATUS);
  wire hitA      = (paddr == ssnu_pkg::OFS_REG_A);
  wire hitB      = (paddr == ssnu_pkg::OFS_REG_B);
  wire hitC      = (paddr == ssnu_pkg::OFS_REG_C);
  wire hitLine   = (paddr == ssnu_pkg::OFS_LINE);
  wire mapped    = hitCtrl || hitStat || hitA || hitB || hitC || hitLine;
  wire wrEn      = apbAccess && pwrite && mapped;
  wire idleWr    = wrEn && !active && !pending_q;
  wire startCmd  = idleWr && hitCtrl && pwdata[ssnu_pkg::CTRL_GO_BIT];

  wire [ssnu_pkg::DATA_W-1:0] statusWord =
    {19'h00000, bitIdx_q, 4'h0, busy, overflow_q, lookupPhase, runPhase};
  wire [ssnu_pkg::DATA_W-1:0] readMux =
    hitCtrl ? {26'h0000000, opc_q} :
    hitStat ? statusWord :
    hitA    ? {8'h00, regA_q} :
    hitB    ? {8'h00, regB_q} :
    hitC    ? {8'h00, regC_q} :
    hitLine ? {21'h000000, lineSel_q, 2'h0, lineNum_q} :
              32'h00000000;

  assign pready          = ce;
  assign pslverr         = psel && penable && !mapped;
  assign prdata          = rdata_q;
  assign runPhaseFlag    = runPhase;
  assign lookupPhaseFlag = lookupPhase;
  assign overflowFlag    = overflow_q;
  assign busy            = active || pending_q;

  // Bit-time counter runs free so word boundaries stay fixed
  always_ff @(posedge clk)
  begin
    if (rst)
      bitIdx_q <= ssnu_pkg::IDX_P1;
    else if (ce)
      bitIdx_q <= p24 ? ssnu_pkg::IDX_P1
                      : bitIdx_q + 5'h01;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      phase_q <= ssnu_pkg::PH_IDLE;
    else if (ce)
      phase_q <= phase_d;
  end

  // Commands start on a word boundary so registers end aligned
  always_ff @(posedge clk)
  begin
    if (rst)
      pending_q <= 1'b0;
    else if (ce)
      pending_q <= startCmd || (pending_q && !p24);
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      opc_q <= ssnu_pkg::RST_OPC;
    else if (ce)
    begin
      if (idleWr && hitCtrl)
        opc_q <= pwdata[ssnu_pkg::OPC_W-1:0];
      if (inRun && isArith && opcodeBit2 && p24)
        opc_q[ssnu_pkg::OPC_B2] <= 1'b0;
      if (normStop)
        opc_q[ssnu_pkg::OPC_B3] <= 1'b1;
    end
  end

  // Carry is left alone at P24 of an add/subtract run so double words chain
  always_ff @(posedge clk)
  begin
    if (rst)
      serialCinLatch_q <= 1'b0;
    else if (ce)
    begin
      if (startCmd)
        serialCinLatch_q <= 1'b0;
      else if (subPreset)
        serialCinLatch_q <= 1'b1;
      else if (lookupPhase)
        serialCinLatch_q <= 1'b0;
      else if (inRun && isShift && p24)
        serialCinLatch_q <= 1'b0;
      else if (carrySet)
        serialCinLatch_q <= 1'b1;
      else if (carryClr)
        serialCinLatch_q <= 1'b0;
    end
  end

  // Set wins over the clear from a new command
  always_ff @(posedge clk)
  begin
    if (rst)
      overflow_q <= 1'b0;
    else if (ce)
    begin
      if (ovfEvent)
        overflow_q <= 1'b1;
      else if (startCmd)
        overflow_q <= 1'b0;
    end
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      aDelayBit_q   <= 1'b0;
      bDelayBit_q   <= 1'b0;
      bToALinkBit_q <= 1'b0;
    end
    else if (ce)
    begin
      if (inRun && isShift)
      begin
        aDelayBit_q <= aReadBit;
        bDelayBit_q <= bReadBit;
      end
      if (active && isShift && p24)
        bToALinkBit_q <= bWriteBit;
    end
  end

  // Circulating registers move only while a command owns them
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      regA_q <= ssnu_pkg::RST_WORD;
      regB_q <= ssnu_pkg::RST_WORD;
      regC_q <= ssnu_pkg::RST_WORD;
    end
    else if (ce)
    begin
      if (active)
      begin
        regA_q <= {aWriteBit, regA_q[W-1:1]};
        regB_q <= {bWriteBit, regB_q[W-1:1]};
        regC_q <= {cWriteBit, regC_q[W-1:1]};
      end
      else if (idleWr)
      begin
        if (hitA)
          regA_q <= pwdata[W-1:0];
        if (hitB)
          regB_q <= pwdata[W-1:0];
        if (hitC)
          regC_q <= pwdata[W-1:0];
      end
    end
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lineNum_q <= ssnu_pkg::RST_LINE;
      lineSel_q <= ssnu_pkg::RST_SEL;
    end
    else if (idleWr && hitLine)
    begin
      lineNum_q <= pwdata[5:0];
      lineSel_q <= pwdata[ssnu_pkg::LINE_SEL_LSB+2:ssnu_pkg::LINE_SEL_LSB];
    end
  end

  // Read data is captured in the setup cycle
  always_ff @(posedge clk)
  begin
    if (rst)
      rdata_q <= 32'h00000000;
    else if (apbSetup)
      rdata_q <= readMux;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_bit_wrap: assert property (ce && p24 |=> p1)
    else $error("bit time did not wrap to P1 after P24");
  a_run_set: assert property (
    ce && phase_q == ssnu_pkg::PH_LOOKUP && p24 && isArith &&
    !addressMatchFlag |=> runPhaseFlag && lookupPhaseFlag)
    else $error("run flag not set at lookup P24");
  a_carry_set: assert property (ce && carrySet && !subPreset
    |=> serialCinLatch_q)
    else $error("carry latch failed to set");
  a_carry_clr: assert property (ce && carryClr |=>
    !serialCinLatch_q)
    else $error("carry latch failed to clear");
  a_sub_preset: assert property (ce && subPreset
    |=> serialCinLatch_q && inRun)
    else $error("subtract carry preset missing");
  a_ovf_set: assert property (ce && ovfEvent |=>
    overflowFlag [*2])
    else $error("overflow flag not set or not held");
  a_double_word: assert property (
    ce && inRun && isArith && opcodeBit2 && p24 |=>
    inRun && !opcodeBit2)
    else $error("double length did not move to second word");
  a_single_exit: assert property (
    ce && inRun && isArith && !opcodeBit2 && p24 |=> !runPhaseFlag)
    else $error("single word command did not end");
  a_shift_direct: assert property (
    ce && phase_q == ssnu_pkg::PH_LOOKUP && isShift && p24
    |=> !lookupPhaseFlag && runPhaseFlag)
    else $error("shift command entered wait phase");
  a_norm_stop: assert property (ce && normStop
    |=> opcodeBit3 && aWriteBit == aReadBit)
    else $error("normalize did not terminate");
  a_shift_exit: assert property (
    ce && inRun && isShift && p24 && addressMatchFlag |=> !busy)
    else $error("shift did not leave run on match");
endmodule : ssnu_core
`default_nettype wire

// *** tb/ssnu_mem_model.sv ***
// Circulating memory model: feeds the fetch gate and the address match
`default_nettype none
module ssnu_mem_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        lookupPhaseFlag,
  input  wire logic        runPhaseFlag,
  input  wire logic [47:0] operand,
  input  wire logic [3:0]  lookWait,
  input  wire logic [3:0]  runWords,
  output logic             memoryFetchBit,
  output logic             addressMatchFlag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] bitIdx_q;
  logic [3:0] lookCnt_q;
  logic [3:0] runCnt_q;
  logic       toggle_q;
  logic       runOnly;
  logic       wordEnd;
  assign runOnly = runPhaseFlag && !lookupPhaseFlag;
  assign wordEnd = bitIdx_q == 5'h17;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bitIdx_q  <= 5'h00;
      lookCnt_q <= 4'h0;
      runCnt_q  <= 4'h0;
      toggle_q  <= 1'b0;
    end
    else if (ce)
    begin
      bitIdx_q  <= wordEnd ? 5'h00 : bitIdx_q + 5'h01;
      toggle_q  <= !toggle_q;
      lookCnt_q <= !lookupPhaseFlag ? 4'h0 : lookCnt_q + {3'h0, wordEnd};
      runCnt_q  <= !runOnly ? 4'h0 : runCnt_q + {3'h0, wordEnd};
    end
  end
  // Outside its two words the line shows a changing pattern, never a hold
  assign memoryFetchBit = (!runOnly || runCnt_q > 4'h1) ? toggle_q :
                          operand[{runCnt_q[0], 5'h00} - {runCnt_q[0], 3'h0}
                                  + {1'b0, bitIdx_q}];
  // A slow line holds the match back for lookWait words
  assign addressMatchFlag = lookupPhaseFlag ? lookCnt_q >= lookWait :
                            runOnly && runCnt_q + 4'h1 >= runWords;
endmodule : ssnu_mem_model
`default_nettype wire

// *** tb/ssnu_core_tb.sv ***
// Self-checking bench for the serial add, shift and normalize unit
`default_nettype none
module ssnu_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk;
  logic        rst;
  logic        ce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        fetchBit;
  logic        matchFlag;
  logic        runFlag;
  logic        lookFlag;
  logic        ovfFlag;
  logic        busy;
  logic [47:0] operand;
  logic [3:0]  lookWait;
  logic [3:0]  runWords;
  int          n_errors;
  int          comparisons;
  int          seed;
  ssnu_core ssnu_core_i (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .memoryFetchBit(fetchBit), .addressMatchFlag(matchFlag),
    .runPhaseFlag(runFlag), .lookupPhaseFlag(lookFlag),
    .overflowFlag(ovfFlag), .busy(busy));
  ssnu_mem_model ssnu_mem_model_i (.clk(clk), .rst(rst), .ce(ce),
    .lookupPhaseFlag(lookFlag), .runPhaseFlag(runFlag), .operand(operand),
    .lookWait(lookWait), .runWords(runWords), .memoryFetchBit(fetchBit),
    .addressMatchFlag(matchFlag));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic conclude();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input logic [31:0] mask, input string what);
    comparisons++;
    if ((got & mask) !== (exp & mask))
    begin
      $display("wrong value at %0t: %s", $time, what);
      n_errors++;
    end
  endtask : chk
  task automatic timeout();
    $display("wrong value at %0t: no answer in time", $time);
    n_errors++;
    conclude();
  endtask : timeout
  // Entered just after a rising edge; leaves one idle cycle behind it
  task automatic apb(input logic wr, input logic [7:0] addr,
                     input logic [31:0] wdata, output logic [31:0] rdata,
                     output logic err);
    int i;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= addr;
    pwdata <= wdata;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (i == 16)
      timeout();
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask : rd
  // Polls status; notes whether run and lookup were ever seen together
  task automatic run_cmd(input logic [5:0] op, input logic [23:0] a,
      input logic [23:0] b, input logic [23:0] c, input logic [10:0] line,
      output logic [31:0] ra, output logic [31:0] rb,
      output logic [31:0] rc, output logic [31:0] st, output logic sw);
    int i;
    wr(ssnu_pkg::OFS_REG_A, {8'h00, a});
    wr(ssnu_pkg::OFS_REG_B, {8'h00, b});
    wr(ssnu_pkg::OFS_REG_C, {8'h00, c});
    wr(ssnu_pkg::OFS_LINE, {21'h0, line});
    wr(ssnu_pkg::OFS_CTRL, {23'h0, 1'b1, 2'h0, op});
    wr(ssnu_pkg::OFS_REG_A, {8'h00, ~a});
    sw = 1'b0;
    for (i = 0; i < 400; i++)
    begin
      rd(ssnu_pkg::OFS_STATUS, st);
      sw = sw | (st[0] & st[1]);
      if (st[3] === 1'b0)
        break;
    end
    if (i == 400)
      timeout();
    rd(ssnu_pkg::OFS_REG_A, ra);
    rd(ssnu_pkg::OFS_REG_B, rb);
    rd(ssnu_pkg::OFS_REG_C, rc);
  endtask : run_cmd
  // Bit-serial adder walked one bit time at a time: {overflow, A, B}
  function automatic logic [48:0] arith(input logic [5:0] op,
      input logic [23:0] a, input logic [23:0] b, input logic [47:0] m);
    logic [23:0] ra;
    logic [23:0] rb;
    logic        c;
    logic        x;
    logic        y;
    logic        hiB;
    logic        ovf;
    ra = a;
    rb = b;
    c = op[0];
    hiB = op[1];
    ovf = 1'b0;
    for (int w = 0; w < (op[1] ? 2 : 1); w++)
    begin
      for (int k = 0; k < 24; k++)
      begin
        x = m[w * 24 + k] ^ op[0];
        y = hiB ? rb[k] : ra[k];
        if (k == 22 && !hiB)
          ovf = ovf | (x == y && x != c);
        if (hiB)
          rb[k] = x ^ y ^ c;
        else
          ra[k] = x ^ y ^ c;
        if (k != 0 && k != 23 && x == y)
          c = x;
      end
      hiB = 1'b0;
    end
    return {ovf, ra, rb};
  endfunction : arith
  initial
  begin : main
    logic [31:0] t;
    logic [31:0] r;
    logic [31:0] ra;
    logic [31:0] rb;
    logic [31:0] rc;
    logic [31:0] st;
    logic        e;
    logic        sw;
    logic [5:0]  op;
    logic [23:0] a;
    logic [23:0] b;
    logic [23:0] c;
    logic [23:0] eA;
    logic [23:0] mA;
    logic [5:0]  lnum;
    logic [1:0]  sel;
    logic [3:0]  sh;
    logic [48:0] ex;
    seed = 61252;
    n_errors = 0;
    comparisons = 0;
    rst = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    operand = 48'h0;
    lookWait = 4'h0;
    runWords = 4'h1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 6; i++)
    begin
      rd(8'(i * 4), r);
      chk(r, 32'h0, (i == 1) ? 32'hff : 32'hffffffff, "reset value");
    end
    apb(1'b0, 8'h18, 32'h0, r, e);
    chk({e, r[30:0]}, 32'h80000000, 32'hffffffff, "unmapped read");
    for (int i = 0; i < 24; i++)
    begin
      op = 6'h0c + {4'h0, i[1:0]};
      t = $random(seed);
      a = t[23:0];
      t = $random(seed);
      b = t[23:0];
      c = t[31:8];
      operand = 48'({$random(seed), $random(seed)});
      // Corners: carry up through the bits below the sign, then all zero operands
      if (i < 4)
      begin
        a = 24'h3fffff;
        operand = {2{24'h3fffff}};
      end
      else if (i < 8)
      begin
        a = 24'h0;
        b = 24'h0;
        operand = 48'h0;
      end
      lookWait = 4'(i % 3);
      run_cmd(op, a, b, c, 11'h0, ra, rb, rc, st, sw);
      ex = arith(op, a, b, operand);
      chk(ra, {8'h00, ex[47:24]}, 32'hffffffff, "A sum");
      chk(rb, {8'h00, ex[23:0]}, 32'hffffffff, "B sum");
      chk(rc, {8'h00, c}, 32'hffffffff, "C kept");
      chk(st, {29'h0, ex[48], 2'h0}, 32'h7, "status");
      chk({28'h0, busy, ovfFlag, lookFlag, runFlag}, {29'h0, ex[48], 2'h0},
          32'hf, "pins");
      chk({31'h0, sw}, {31'h0, lookWait != 4'h0}, 32'h1, "wait");
    end
    for (int i = 0; i < 16; i++)
    begin
      op = 6'h10 + {5'h0, i[0]};
      t = $random(seed);
      a = t[23:0];
      sel = t[25:24];
      sh = op[0] ? {2'h0, t[27:26]} + 4'h1 : 4'h1;
      lnum = t[31:26];
      lnum[sel] = op[0] ? t[29] : 1'b1;
      t = $random(seed);
      b = t[23:0];
      t = $random(seed);
      c = t[23:0];
      // A normalized operand must stop after the first word
      if (!op[0])
        a[21] = ~a[22];
      runWords = op[0] ? sh : 4'h3;
      lookWait = 4'h3;
      run_cmd(op, a, b, c, {1'b0, sel, 2'h0, lnum}, ra, rb, rc, st, sw);
      mA = ((24'h3fffff >> (sh + 4'h1)) << (sh + 4'h1)) | 24'h400000;
      // Shifted bits stop below the sign, which keeps its own value
      eA = (((a >> 1) << (sh + 4'h1)) & 24'h3fffff) | (a & 24'h400000);
      if (sh == 4'h1)
      begin
        mA[1] = 1'b1;
        eA[1] = b[23];
      end
      chk(ra, {8'h00, eA}, {8'h00, mA}, "A shift");
      chk(rb, {8'h00, (b >> 1) << (sh + 4'h1)},
          op[0] ? 32'hfffffe : 32'h3ffffc, "B shift");
      chk(rc, {8'h00, lnum[sel] ? c : {c[23:1] - {19'h0, sh}, c[0]}},
          32'hffffffff, "C count");
      chk(st, 32'h0, 32'h7, "status");
      chk({28'h0, busy, ovfFlag, lookFlag, runFlag}, 32'h0,
          32'hf, "pins");
      chk({31'h0, sw}, 32'h0, 32'h1, "wait");
    end
    conclude();
  end
endmodule : ssnu_core_tb
`default_nettype wire
